// ==== src/fade_gain_pkg.sv ====
// Purpose: shared constants for the fade gain step sequencer
// Assumes: 125 MHz system clock, 32-bit AHB-Lite register access
// Notes: level codes are 8-bit converter codes referenced to the supply
package fade_gain_pkg;

  // clock and slow step clock
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned TICK_HZ = 58;
  localparam int unsigned STEP_MS = 34;
  localparam int unsigned TICK_DIV_DEF = CLK_HZ / TICK_HZ;
  localparam int unsigned DIV_W = 22;
  localparam int unsigned TICKS_PER_STEP = 2;

  // gain step index
  localparam int unsigned STEP_W = 5;
  localparam logic [4:0] STEP_MIN = 5'h00;
  localparam logic [4:0] STEP_MAX = 5'h1f;
  localparam int unsigned STEP_MAX_DB = 18;
  localparam logic [4:0] SE_DROP_STEPS = 5'h03;

  // level code quantiser: 8 codes per step, gap of HYST codes at each edge
  localparam int unsigned LVL_W = 8;
  localparam int unsigned LVL_SUB_W = 3;
  localparam logic [2:0] HYST_CODES = 3'h1;
  localparam int unsigned NUM_QUANT = 3;

  // register byte addresses
  localparam logic [7:0] LEVEL_ADDR = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam logic [7:0] SAVED_ADDR = 8'h08;
  localparam logic [31:0] LEVEL_RESET = 32'h0000_0000;

  // level register fields
  localparam int unsigned SPK_LSB = 0;
  localparam int unsigned OFS_LSB = 8;
  localparam int unsigned CAP_LSB = 16;

  // status register fields
  localparam int unsigned ST_GAIN_LSB = 0;
  localparam int unsigned ST_TARGET_LSB = 8;
  localparam int unsigned ST_STATE_LSB = 16;
  localparam int unsigned ST_MUTE_BIT = 24;

  // pin synchroniser bit positions
  localparam int unsigned PIN_SD_N = 0;
  localparam int unsigned PIN_FADE = 1;
  localparam int unsigned PIN_MODE = 2;
  localparam int unsigned PIN_CHG = 3;
  localparam int unsigned PIN_DIS = 4;
  localparam int unsigned NUM_PINS = 5;

  // sequencer states
  typedef enum logic [2:0] {
    ST_PWR_CHARGE,
    ST_UP_RAMP,
    ST_ACTIVE,
    ST_DOWN_RAMP,
    ST_DISCHARGE,
    ST_OFF,
    ST_CHARGE
  } seq_state_t;

endpackage

// ==== src/fade_gain_step_sequencer.sv ====
// Purpose: gain step fade sequencer and level-to-step selection with hysteresis
// Assumes: pins are asynchronous; level codes are written over AHB-Lite
// Notes: bypass node charge state comes back on two status pins from the analog side
`timescale 1ns/100ps

module fade_gain_step_sequencer
  import fade_gain_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_DIV_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // control pins from the host
  input wire logic shutdown_n,
  input wire logic fade_sel,
  input wire logic output_mode_sel,
  // bypass node state from the analog side
  input wire logic bypass_charged,
  input wire logic bypass_discharged,
  // amplifier controls
  output logic [4:0] gain_step,
  output logic mute,
  output logic bypass_charge_en,
  output logic bypass_discharge_en,
  output logic neg_driver_en,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);

  initial begin
    if (TICK_DIV < 1 || TICK_DIV >= (1 << DIV_W)) begin
      $error("TICK_DIV out of range");
    end
  end

  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_DIV - 1);

  //--------------------------------------------------------------
  // state
  //--------------------------------------------------------------
  typedef struct packed {
    logic [NUM_PINS-1:0] pin_meta;
    logic [NUM_PINS-1:0] pin_sync;
    logic [DIV_W-1:0] div;
    logic phase;
    seq_state_t state;
    logic [4:0] gain;
    logic [4:0] saved;
    logic mute;
    logic [NUM_QUANT-1:0][4:0] held;
    logic [LVL_W-1:0] spk_lvl;
    logic [LVL_W-1:0] ofs_lvl;
    logic [LVL_W-1:0] cap_lvl;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
  } state_t;

  state_t s_q;
  state_t s_d;

  //--------------------------------------------------------------
  // helpers
  //--------------------------------------------------------------
  // clamp the held step into the band that a code allows; inside a
  // gap either neighbour is legal, so the held one stays
  function automatic logic [4:0] quantise(input logic [4:0] held, input logic [LVL_W-1:0] code);
    logic [4:0] cand;
    logic [2:0] sub;
    logic [4:0] lo;
    logic [4:0] hi;
    cand = code[LVL_W-1:LVL_SUB_W];
    sub = code[LVL_SUB_W-1:0];
    lo = cand;
    hi = cand;
    if (sub < HYST_CODES && cand != STEP_MIN) begin
      lo = cand - 5'h01;
    end
    if (sub > (3'h7 - HYST_CODES) && cand != STEP_MAX) begin
      hi = cand + 5'h01;
    end
    if (held < lo) begin
      quantise = lo;
    end else if (held > hi) begin
      quantise = hi;
    end else begin
      quantise = held;
    end
  endfunction

  //--------------------------------------------------------------
  // next-state logic
  //--------------------------------------------------------------
  logic sd_n;
  logic fade_ramp;
  logic se_mode;
  logic charged;
  logic discharged;
  logic tick;
  logic step_now;
  logic [LVL_W-1:0] se_lvl;
  logic [4:0] spk_step;
  logic [4:0] se_step;
  logic [4:0] cap_step;
  logic [4:0] se_target;
  logic [4:0] target;
  logic addr_ok;

  // level codes are converter codes relative to the supply, so the
  // fixed thresholds below follow the supply without any arithmetic
  always_comb begin
    s_d = s_q;
    sd_n = s_q.pin_sync[PIN_SD_N];
    fade_ramp = ~s_q.pin_sync[PIN_FADE];
    se_mode = s_q.pin_sync[PIN_MODE];
    charged = s_q.pin_sync[PIN_CHG];
    discharged = s_q.pin_sync[PIN_DIS];

    // two-stage synchronisers
    s_d.pin_meta = {bypass_discharged, bypass_charged, output_mode_sel, fade_sel, shutdown_n};
    s_d.pin_sync = s_q.pin_meta;

    // slow tick, one step every two ticks
    tick = (s_q.div == DIV_LAST);
    s_d.div = tick ? '0 : s_q.div + 1'b1;
    s_d.phase = tick ? ~s_q.phase : s_q.phase;
    step_now = tick && s_q.phase;

    // level to step selection
    se_lvl = (s_q.ofs_lvl > s_q.spk_lvl) ? '0 : s_q.spk_lvl - s_q.ofs_lvl;
    s_d.held[0] = quantise(s_q.held[0], s_q.spk_lvl);
    s_d.held[1] = quantise(s_q.held[1], se_lvl);
    s_d.held[2] = quantise(s_q.held[2], s_q.cap_lvl);
    spk_step = s_q.held[0];
    // single-ended drive halves the swing, so drop 6 dB worth of steps
    se_step = (s_q.held[1] > SE_DROP_STEPS) ? s_q.held[1] - SE_DROP_STEPS : STEP_MIN;
    cap_step = s_q.held[2];
    se_target = (se_step < cap_step) ? se_step : cap_step;
    target = se_mode ? se_target : spk_step;

    // sequencer
    unique case (s_q.state)
      ST_PWR_CHARGE: begin
        s_d.gain = STEP_MIN;
        s_d.mute = 1'b1;
        if (charged) begin
          s_d.state = ST_UP_RAMP;
          s_d.mute = 1'b0;
          s_d.phase = 1'b0;
        end
      end
      ST_UP_RAMP: begin
        if (!sd_n) begin
          if (fade_ramp) begin
            s_d.state = ST_DOWN_RAMP;
            s_d.phase = 1'b0;
          end else begin
            s_d.saved = s_q.gain;
            s_d.mute = 1'b1;
            s_d.state = ST_DISCHARGE;
          end
        end else if (s_q.gain >= target) begin
          s_d.state = ST_ACTIVE;
        end else if (step_now && s_q.gain != STEP_MAX) begin
          s_d.gain = s_q.gain + 5'h01;
        end
      end
      ST_ACTIVE: begin
        s_d.gain = target;
        if (!sd_n) begin
          if (fade_ramp) begin
            s_d.gain = s_q.gain;
            s_d.state = ST_DOWN_RAMP;
            s_d.phase = 1'b0;
          end else begin
            s_d.gain = s_q.gain;
            s_d.saved = s_q.gain;
            s_d.mute = 1'b1;
            s_d.state = ST_DISCHARGE;
          end
        end
      end
      ST_DOWN_RAMP: begin
        if (sd_n) begin
          s_d.state = ST_UP_RAMP;
          s_d.phase = 1'b0;
        end else if (s_q.gain == STEP_MIN) begin
          s_d.mute = 1'b1;
          s_d.state = ST_DISCHARGE;
        end else if (step_now) begin
          s_d.gain = s_q.gain - 5'h01;
        end
      end
      ST_DISCHARGE: begin
        if (sd_n) begin
          s_d.state = ST_CHARGE;
        end else if (discharged) begin
          s_d.state = ST_OFF;
        end
      end
      ST_OFF: begin
        if (sd_n) begin
          s_d.state = ST_CHARGE;
        end
      end
      ST_CHARGE: begin
        if (!sd_n) begin
          s_d.state = ST_DISCHARGE;
        end else if (charged) begin
          s_d.mute = 1'b0;
          if (fade_ramp) begin
            s_d.gain = STEP_MIN;
            s_d.phase = 1'b0;
            s_d.state = ST_UP_RAMP;
          end else begin
            s_d.gain = s_q.saved;
            s_d.state = ST_ACTIVE;
          end
        end
      end
      default: begin
        s_d.state = ST_PWR_CHARGE;
      end
    endcase

    // ahb-lite: zero wait, read data prepared in the address phase
    addr_ok = hsel && htrans[1] && hready;
    s_d.wr_pend = addr_ok && hwrite;
    s_d.wr_addr = haddr[7:0];
    if (s_q.wr_pend && s_q.wr_addr == LEVEL_ADDR) begin
      s_d.spk_lvl = hwdata[SPK_LSB +: LVL_W];
      s_d.ofs_lvl = hwdata[OFS_LSB +: LVL_W];
      s_d.cap_lvl = hwdata[CAP_LSB +: LVL_W];
    end
    s_d.rdata = '0;
    if (addr_ok && !hwrite) begin
      unique case (haddr[7:0])
        LEVEL_ADDR: begin
          s_d.rdata[SPK_LSB +: LVL_W] = s_q.spk_lvl;
          s_d.rdata[OFS_LSB +: LVL_W] = s_q.ofs_lvl;
          s_d.rdata[CAP_LSB +: LVL_W] = s_q.cap_lvl;
        end
        STATUS_ADDR: begin
          s_d.rdata[ST_GAIN_LSB +: STEP_W] = s_q.gain;
          s_d.rdata[ST_TARGET_LSB +: STEP_W] = target;
          s_d.rdata[ST_STATE_LSB +: 3] = s_q.state;
          s_d.rdata[ST_MUTE_BIT] = s_q.mute;
        end
        SAVED_ADDR: begin
          s_d.rdata[STEP_W-1:0] = s_q.saved;
        end
        default: begin
          s_d.rdata = '0; // unmapped reads as zero
        end
      endcase
    end
  end

  //--------------------------------------------------------------
  // registers
  //--------------------------------------------------------------
  // power-up is reset: ramp starts from the lowest step
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '{
        pin_meta: '0, pin_sync: '0, div: '0, phase: 1'b0,
        state: ST_PWR_CHARGE, gain: STEP_MIN, saved: STEP_MIN, mute: 1'b1,
        held: '0, spk_lvl: LEVEL_RESET[SPK_LSB +: LVL_W],
        ofs_lvl: LEVEL_RESET[OFS_LSB +: LVL_W], cap_lvl: LEVEL_RESET[CAP_LSB +: LVL_W],
        wr_pend: 1'b0, wr_addr: '0, rdata: '0
      };
    end else begin
      s_q <= s_d;
    end
  end

  //--------------------------------------------------------------
  // outputs
  //--------------------------------------------------------------
  assign gain_step = s_q.gain;
  assign mute = s_q.mute;
  assign bypass_charge_en = (s_q.state == ST_CHARGE) || (s_q.state == ST_PWR_CHARGE) ||
                            (s_q.state == ST_UP_RAMP) || (s_q.state == ST_ACTIVE) ||
                            (s_q.state == ST_DOWN_RAMP);
  assign bypass_discharge_en = (s_q.state == ST_DISCHARGE) || (s_q.state == ST_OFF);
  assign neg_driver_en = ~s_q.pin_sync[PIN_MODE];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s_q.rdata;

endmodule // fade_gain_step_sequencer

// ==== tb/bypass_node_model.sv ====
// Purpose: behavioural stand-in for the midrail bypass node
// Assumes: linear charge and discharge, one count per clock
// Notes: DELAY sets how slowly the node answers
`timescale 1ns/100ps
module bypass_node_model #(
  parameter int DELAY = 20
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // drive requests from the block
  input wire logic charge_en,
  input wire logic discharge_en,
  // node state back to the block
  output logic charged,
  output logic discharged
);
  int lvl_q;
  // node walks toward the driven rail and parks there when left alone
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) lvl_q <= 0;
    else if (charge_en && lvl_q < DELAY) lvl_q <= lvl_q + 1;
    else if (discharge_en && lvl_q > 0) lvl_q <= lvl_q - 1;
  end
  assign charged = (lvl_q == DELAY);
  assign discharged = (lvl_q == 0);
endmodule // bypass_node_model

// ==== tb/fade_gain_step_sequencer_sva.sv ====
// Purpose: port checker for the fade gain step sequencer
// Assumes: TICK_DIV handed on from the bound instance
// Notes: step spacing measured by a small helper counter
`timescale 1ns/100ps
module fade_gain_sva #(
  parameter int unsigned TICK_DIV = 4
) (
  // clock, reset and pins
  input wire logic clk,
  input wire logic reset_n,
  input wire logic shutdown_n,
  input wire logic fade_sel,
  input wire logic output_mode_sel,
  input wire logic bypass_charged,
  // amplifier controls
  input wire logic [4:0] gain_step,
  input wire logic mute,
  input wire logic bypass_charge_en,
  input wire logic bypass_discharge_en,
  input wire logic neg_driver_en
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [4:0] prev_q;
  logic [15:0] since_q;
  // cycles since the step last moved; wraps after long idle, harmless for short runs
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prev_q <= 5'h00;
      since_q <= 16'h0000;
    end else begin
      prev_q <= gain_step;
      since_q <= (gain_step != prev_q) ? 16'h0000 : since_q + 16'h0001;
    end
  end
  property p_neg_drv;
    $stable(output_mode_sel) [*4] |-> neg_driver_en == !output_mode_sel;
  endproperty
  a_neg_drv: assert property (p_neg_drv)
    else $error("negative drivers disagree with mode pin");
  property p_down_gap;
    !shutdown_n && !fade_sel && gain_step != prev_q |->
      gain_step == prev_q - 5'h01 && since_q >= 16'(2 * TICK_DIV - 1);
  endproperty
  a_down_gap: assert property (p_down_gap)
    else $error("down step size or spacing wrong");
  property p_up_gap;
    gain_step == prev_q + 5'h01 |-> since_q >= 16'(2 * TICK_DIV - 1);
  endproperty
  a_up_gap: assert property (p_up_gap)
    else $error("up step came too soon");
  property p_disch_floor;
    $rose(bypass_discharge_en) && !fade_sel |-> gain_step == 5'h00 && mute;
  endproperty
  a_disch_floor: assert property (p_disch_floor)
    else $error("discharge began above lowest step");
  property p_mute_disch;
    $rose(mute) |-> ##[0:2] bypass_discharge_en;
  endproperty
  a_mute_disch: assert property (p_mute_disch)
    else $error("mute not followed by discharge");
  property p_imm_mute;
    $fell(shutdown_n) && fade_sel |-> ##[1:5] mute;
  endproperty
  a_imm_mute: assert property (p_imm_mute)
    else $error("immediate shutdown did not mute");
  property p_unmute;
    $fell(mute) |-> bypass_charged && !bypass_discharge_en;
  endproperty
  a_unmute: assert property (p_unmute)
    else $error("unmuted before node charged");
  property p_charge_floor;
    bypass_charge_en && mute && !fade_sel |-> gain_step == 5'h00;
  endproperty
  a_charge_floor: assert property (p_charge_floor)
    else $error("step not lowest while charging");
endmodule // fade_gain_sva
bind fade_gain_step_sequencer fade_gain_sva #(.TICK_DIV(TICK_DIV)) sva_u (.clk(clk), .reset_n(reset_n),
  .shutdown_n(shutdown_n), .fade_sel(fade_sel), .output_mode_sel(output_mode_sel),
  .bypass_charged(bypass_charged), .gain_step(gain_step), .mute(mute), .bypass_charge_en(bypass_charge_en),
  .bypass_discharge_en(bypass_discharge_en), .neg_driver_en(neg_driver_en));

// ==== tb/test_fade_gain_step_sequencer.sv ====
// Purpose: self-checking bench for the fade gain step sequencer
// Assumes: slow tick shortened to TDIV clocks, two ticks per step
// Notes: level codes sit mid-range of their step unless probing hysteresis
`timescale 1ns/100ps
module test_fade_gain_step_sequencer;
  import fade_gain_pkg::*;
  localparam int unsigned TDIV = 4;
  localparam logic [31:0] LVL = 32'h0;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic shutdown_n = 1'b1;
  logic fade_sel = 1'b0;
  logic output_mode_sel = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'b010;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic charged, discharged, charge_en, discharge_en, mute, neg_driver_en, hreadyout, hresp;
  logic [4:0] gain_step;
  logic [31:0] hrdata;
  int failures = 0;
  int tests_run = 0;
  // free-running system clock
  always #4 clk = ~clk;
  fade_gain_step_sequencer #(.TICK_DIV(TDIV)) dut_u (.clk(clk), .reset_n(reset_n), .shutdown_n(shutdown_n),
    .fade_sel(fade_sel), .output_mode_sel(output_mode_sel), .bypass_charged(charged),
    .bypass_discharged(discharged), .gain_step(gain_step), .mute(mute), .bypass_charge_en(charge_en),
    .bypass_discharge_en(discharge_en), .neg_driver_en(neg_driver_en), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
  bypass_node_model #(.DELAY(20)) node_u (.clk(clk), .reset_n(reset_n), .charge_en(charge_en),
    .discharge_en(discharge_en), .charged(charged), .discharged(discharged));
  task automatic close_out();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      failures++;
    end
  endtask
  // one single transfer; address phase held until hready, data taken at the closing edge
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 50);
    htrans <= 2'b00;
    hwdata <= d;
    do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 100);
    r = hrdata;
    if (n >= 100) begin failures++; close_out(); end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rd(input string what, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    check(what, r, exp);
  endtask
  // bounded wait for a step (bit 5 set: any step) and a mute level
  task automatic wait_out(input logic [5:0] g, input logic m, output int n);
    n = 0;
    while (!((g[5] || gain_step === g[4:0]) && mute === m) && n < 2000) begin @(posedge clk); n++; end
    if (n >= 2000) begin
      $display("CHECK FAILED wait expected %h seen %h", g, gain_step);
      failures++;
      close_out();
    end
  endtask
  task automatic t_power_up();
    int n;
    check("reset step", {27'h0, gain_step}, 32'h0);
    check("reset mute", {31'h0, mute}, 32'h1);
    wr(LVL, 32'h00fc_0054); // speaker code centred in step 10
    wait_out(6'h0a, 1'b0, n);
    check("slow power-up", 32'(n >= 80), 32'h1);
  endtask
  task automatic t_target();
    logic [39:0] tbl [7] = '{40'h00_24_12_54_0a, 40'h01_fc_00_54_07, 40'h01_fc_12_54_05,
      40'h01_24_12_54_04, 40'h01_fc_00_fc_1c, 40'h01_fc_24_0c_00, 40'h00_fc_00_54_0a};
    foreach (tbl[i]) begin
      output_mode_sel <= tbl[i][32];
      wr(LVL, {8'h00, tbl[i][31:8]});
      repeat (8) @(posedge clk);
      check("target", {27'h0, gain_step}, {24'h0, tbl[i][7:0]});
      check("neg drivers", {31'h0, neg_driver_en}, {31'h0, ~tbl[i][32]});
    end
  endtask
  task automatic t_hyst();
    logic [15:0] seq [5] = '{16'h500a, 16'h4f0a, 16'h4e09, 16'h5009, 16'h540a};
    foreach (seq[i]) begin
      wr(LVL, {16'h00fc, 8'h00, seq[i][15:8]});
      repeat (8) @(posedge clk);
      check("held step", {27'h0, gain_step}, {24'h0, seq[i][7:0]});
    end
  endtask
  task automatic t_regs();
    rd("level", LVL, 32'h00fc_0054);
    rd("status", 32'h4, 32'h0002_0a0a);
    wr(32'h4, 32'hffff_ffff);
    rd("status ro", 32'h4, 32'h0002_0a0a);
    rd("unmapped", 32'h10, 32'h0);
    check("okay", {31'h0, hresp}, 32'h0);
  endtask
  task automatic t_fade_ramp();
    int n;
    shutdown_n <= 1'b0;
    wait_out(6'h00, 1'b1, n);
    check("ramp down time", 32'(n >= 72), 32'h1);
    check("discharging", {31'h0, discharge_en}, 32'h1);
    repeat (30) @(posedge clk);
    shutdown_n <= 1'b1;
    wait_out(6'h0a, 1'b0, n);
    check("charge then ramp", 32'(n >= 88), 32'h1);
  endtask
  task automatic t_immediate();
    int n;
    fade_sel <= 1'b1;
    repeat (4) @(posedge clk);
    shutdown_n <= 1'b0;
    wait_out(6'h20, 1'b1, n);
    check("fast mute", 32'(n <= 5), 32'h1);
    rd("saved", 32'h8, 32'h0000_000a);
    repeat (30) @(posedge clk);
    shutdown_n <= 1'b1;
    wait_out(6'h0a, 1'b0, n);
    check("no ramp on restore", 32'(n < 40), 32'h1);
    fade_sel <= 1'b0;
  endtask
  // reset, then every scenario in turn
  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    t_power_up();
    t_target();
    t_hyst();
    t_regs();
    t_fade_ramp();
    t_immediate();
    close_out();
  end
endmodule // test_fade_gain_step_sequencer
